/* shared/wdtl_regs.svh */
/*
  Register map, field positions, reset values and timing counts of the watchdog block.
  Assumes a 12-bit APB byte address and 32-bit data, one register per aligned word.
*/
`ifndef WDTL_REGS_SVH
`define WDTL_REGS_SVH

// Byte offsets on the APB.
`define WDTL_OFS_RSTSRC 12'h054
`define WDTL_OFS_CTRL 12'h060
`define WDTL_OFS_LOCK 12'h064
`define WDTL_OFS_AUX 12'h068

// Control register fields.
`define WDTL_CTRL_IRQ_FLAG 7
`define WDTL_CTRL_IRQ_EN 6
`define WDTL_CTRL_PRESC3 5
`define WDTL_CTRL_CHG_EN 4
`define WDTL_CTRL_RST_EN 3

// Reset source status fields.
`define WDTL_RS_POR 0
`define WDTL_RS_PIN 1
`define WDTL_RS_BOD 2
`define WDTL_RS_WDT 3
`define WDTL_RS_DBG 4
`define WDTL_RS_RESET 5'h01

// Auxiliary register: bit 0 mirrors the CPU global interrupt enable.
`define WDTL_AUX_GIE 0

// Lock register write patterns on bits 2:0.
`define WDTL_LOCK_ARM 3'h7
`define WDTL_LOCK_HI 3'h4
`define WDTL_LOCK_LO 3'h2

// Timed windows in pclk cycles, and the time-out table.
`define WDTL_WINDOW 3'h4
`define WDTL_PRESC_MAX 4'h9
`define WDTL_BASE_SHIFT 11

`endif

/* shared/wdtl_pkg.sv */
/*
  Types of the watchdog block: control register layout, reset source flags, lock states.
  Assumes nothing of its surroundings.
*/
package wdtl_pkg;

  typedef struct packed {
    logic irq_flag;
    logic irq_en;
    logic presc3;
    logic chg_en;
    logic rst_en;
    logic [2:0] presc_lo;
  } wdtl_ctrl_t;

  typedef struct packed {
    logic debug_reset_flag;
    logic timeout_reset_flag;
    logic brownout_reset_flag;
    logic pin_reset_flag;
    logic power_on_flag;
  } wdtl_rstsrc_t;

  typedef enum logic [3:0] {
    lk_open = 4'h1,
    lk_armed = 4'h2,
    lk_lo = 4'h4,
    lk_hi = 4'h8
  } wdtl_lock_state_t;

endpackage

/* hw/wdtl_tick_counter.sv */
/*
  Time-out counter of the watchdog, advanced by oscillator ticks.
  Assumes osc_tick is a one-cycle pulse synchronous to clk, one per oscillator period.
*/
`timescale 1ns/1ps
`default_nettype none

module wdtl_tick_counter #(
  parameter int CNT_W = 21,
  parameter int BASE_SHIFT = 11
) (
  input wire logic clk,                 // System clock.
  input wire logic rst_n,               // Asynchronous reset, active low.
  input wire logic clear,               // Restart from zero.
  input wire logic osc_tick,            // One pulse per oscillator cycle.
  input wire logic [3:0] presc,         // Time-out code, 0 to 9.
  output logic expire,                  // Pulse when the time-out is reached.
  output logic [CNT_W-1:0] count        // Present count.
);

  logic [CNT_W-1:0] limit_m1;
  logic [CNT_W-1:0] count_q;

  // A shorter period chosen while counting fires at once, hence the compare is not an equality.
  assign limit_m1 = (CNT_W'(1) << (BASE_SHIFT + int'(presc))) - CNT_W'(1);
  assign expire = osc_tick && !clear && (count_q >= limit_m1);
  assign count = count_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_q <= '0;
    end
    else if (clear || expire)
    begin
      count_q <= '0;
    end
    else if (osc_tick)
    begin
      count_q <= count_q + CNT_W'(1);
    end
  end

endmodule

`default_nettype wire

/* hw/wdtl_top.sv */
/*
  Watchdog with reset source flags and configuration lock, an APB slave.
  Assumes presetn is the power-on reset, reset events and CPU strobes are synchronous to pclk.
*/
// Contract
// - Count oscillator cycles; act when the selected time-out count is reached.
// - Software restarts in time; a restart instruction clears the counter to zero.
// - Time-out is 2K cycles doubled per code up to 1024K; codes 10-15 reserved.
// - Reset-enable/irq-enable: 00 stopped, 01 irq, 10 reset, 11 irq then reset.
// - Always-on fuse forces reset-only mode: reset-enable one, irq-enable zero.
// - Time-out in irq mode sets flag bit 7; vector or writing one clears it.
// - Interrupt requested only while global and watchdog irq enables are set.
// - In combined mode the vector clears irq-enable and flag, leaving reset-only mode.
// - In combined mode an unserviced flag at the next time-out gives a system reset.
// - Clearing reset-enable or changing prescale only accepted while change-enable is set.
// - Change-enable clears itself four clock cycles after being written to one.
// - Reset-enable stays set while the watchdog reset flag is set.
// - Power-on flag set by power-on reset, cleared only by writing zero.
// - Debug, watchdog, brown-out, pin flags set by their reset; cleared by power-on or zero.
// - Uncleared reset flags persist, so two resets show both sources.
// - Once locked, writes to the locked control bits are ignored until hardware reset.
// - Lock register reads zero in bits 7:3; bits 2:0 reset to zero.
`timescale 1ns/1ps
`default_nettype none
`include "wdtl_regs.svh"

module wdtl_top #(
  parameter int CNT_W = 21
) (
  input wire logic pclk,                // APB clock, 10 MHz.
  input wire logic presetn,             // Power-on reset, active low.
  input wire logic psel,                // APB select.
  input wire logic penable,             // APB access phase.
  input wire logic pwrite,              // APB write.
  input wire logic [11:0] paddr,        // APB byte address.
  input wire logic [31:0] pwdata,       // APB write data.
  output logic [31:0] prdata,           // APB read data.
  output logic pready,                  // APB ready.
  output logic pslverr,                 // APB error on unmapped address.
  input wire logic osc_tick,            // Oscillator cycle pulse.
  input wire logic always_on_fuse,      // Fuse programmed, active high.
  input wire logic restart_instr,       // Watchdog restart instruction pulse.
  input wire logic irq_vector_ack,      // Watchdog vector executes, pulse.
  input wire logic pin_reset_evt,       // Pin reset occurred, pulse.
  input wire logic brownout_reset_evt,  // Brown-out reset occurred, pulse.
  input wire logic debug_reset_evt,     // Debug reset occurred, pulse.
  output logic wdt_irq,                 // Interrupt request, level.
  output logic wdt_reset                // System reset request, one-cycle pulse.
);

  wdtl_pkg::wdtl_ctrl_t ctrl_q;
  wdtl_pkg::wdtl_rstsrc_t flags_q;
  wdtl_pkg::wdtl_lock_state_t lk_q;
  logic [2:0] win_q;
  logic [2:0] lk_win_q;
  logic gie_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic wdt_irq_q;
  logic wdt_reset_q;
  logic [31:0] rd_d;
  logic hit_d;
  logic wr_en;
  logic wr_ctrl;
  logic wr_rs;
  logic wr_lock;
  logic sys_rst;
  logic rst_en_eff;
  logic irq_en_eff;
  logic stopped;
  logic expire;
  logic irq_set;
  logic rst_fire;
  logic lock_hi;
  logic lock_any;
  logic [3:0] presc;
  logic [2:0] lock_rd;
  logic [CNT_W-1:0] count;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: no wait state; every output comes from a flop loaded in the setup phase.

  assign wr_en = psel && penable && pready_q && pwrite;
  assign wr_ctrl = wr_en && (paddr == `WDTL_OFS_CTRL);
  assign wr_rs = wr_en && (paddr == `WDTL_OFS_RSTSRC);
  assign wr_lock = wr_en && (paddr == `WDTL_OFS_LOCK);

  always_comb
  begin
    rd_d = '0;
    hit_d = 1'b1;
    unique case (paddr)
      `WDTL_OFS_RSTSRC: rd_d[4:0] = flags_q;
      `WDTL_OFS_CTRL: rd_d[7:0] = {ctrl_q.irq_flag, irq_en_eff, ctrl_q.presc3, ctrl_q.chg_en,
                                   rst_en_eff, ctrl_q.presc_lo};
      `WDTL_OFS_LOCK: rd_d[2:0] = lock_rd;
      `WDTL_OFS_AUX: rd_d[`WDTL_AUX_GIE] = gie_q;
      default: hit_d = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= psel && !penable;
      prdata_q <= (psel && !penable && !pwrite) ? rd_d : '0;
      pslverr_q <= psel && !penable && !hit_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode and time-out actions.

  assign sys_rst = pin_reset_evt || brownout_reset_evt || debug_reset_evt || wdt_reset_q;
  assign rst_en_eff = ctrl_q.rst_en || flags_q.timeout_reset_flag || always_on_fuse;
  assign irq_en_eff = ctrl_q.irq_en && !always_on_fuse;
  assign stopped = !rst_en_eff && !irq_en_eff;
  assign presc = {ctrl_q.presc3, ctrl_q.presc_lo};
  assign irq_set = expire && irq_en_eff && !(rst_en_eff && ctrl_q.irq_flag);
  assign rst_fire = expire && rst_en_eff && (!irq_en_eff || ctrl_q.irq_flag);
  assign lock_hi = (lk_q == wdtl_pkg::lk_hi);
  assign lock_any = lock_hi || (lk_q == wdtl_pkg::lk_lo);

  // The counter restarts itself on expiry, which keeps interrupt-mode time-outs periodic.
  wdtl_tick_counter #(
    .CNT_W(CNT_W),
    .BASE_SHIFT(`WDTL_BASE_SHIFT)
  ) u_counter (
    .clk(pclk),
    .rst_n(presetn),
    .clear(restart_instr || sys_rst || stopped),
    .osc_tick(osc_tick),
    .presc(presc),
    .expire(expire),
    .count(count)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wdt_irq_q <= 1'b0;
      wdt_reset_q <= 1'b0;
    end
    else
    begin
      wdt_irq_q <= ctrl_q.irq_flag && irq_en_eff && gie_q;
      wdt_reset_q <= rst_fire;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register with timed change window and lock masks.

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= '0;
      win_q <= '0;
    end
    else if (sys_rst)
    begin
      ctrl_q <= '0;
      win_q <= '0;
    end
    else
    begin
      // A time-out setting the flag wins over any clear in the same cycle.
      if (irq_set)
      begin
        ctrl_q.irq_flag <= 1'b1;
      end
      else if (irq_vector_ack || (wr_ctrl && pwdata[`WDTL_CTRL_IRQ_FLAG]))
      begin
        ctrl_q.irq_flag <= 1'b0;
      end
      if (irq_vector_ack && rst_en_eff && irq_en_eff)
      begin
        ctrl_q.irq_en <= 1'b0;
      end
      else if (wr_ctrl && !lock_hi)
      begin
        ctrl_q.irq_en <= pwdata[`WDTL_CTRL_IRQ_EN];
      end
      if (ctrl_q.chg_en)
      begin
        win_q <= win_q - 3'h1;
        if (win_q == 3'h1)
        begin
          ctrl_q.chg_en <= 1'b0;
        end
      end
      else if (wr_ctrl && !lock_any && pwdata[`WDTL_CTRL_CHG_EN] && pwdata[`WDTL_CTRL_RST_EN])
      begin
        ctrl_q.chg_en <= 1'b1;
        win_q <= `WDTL_WINDOW;
      end
      if (flags_q.timeout_reset_flag)
      begin
        ctrl_q.rst_en <= 1'b1;
      end
      else if (wr_ctrl && !lock_any)
      begin
        if (pwdata[`WDTL_CTRL_RST_EN] || (ctrl_q.chg_en && !pwdata[`WDTL_CTRL_CHG_EN]))
        begin
          ctrl_q.rst_en <= pwdata[`WDTL_CTRL_RST_EN];
        end
      end
      // Reserved prescale codes are refused so the count never leaves the table.
      if (wr_ctrl && !lock_any && ctrl_q.chg_en && !pwdata[`WDTL_CTRL_CHG_EN]
          && ({pwdata[`WDTL_CTRL_PRESC3], pwdata[2:0]} <= `WDTL_PRESC_MAX))
      begin
        ctrl_q.presc3 <= pwdata[`WDTL_CTRL_PRESC3];
        ctrl_q.presc_lo <= pwdata[2:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gie_q <= 1'b0;
    end
    else if (sys_rst)
    begin
      gie_q <= 1'b0;
    end
    else if (wr_en && (paddr == `WDTL_OFS_AUX))
    begin
      gie_q <= pwdata[`WDTL_AUX_GIE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset source flags survive every reset but power-on.

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flags_q <= `WDTL_RS_RESET;
    end
    else
    begin
      flags_q.power_on_flag <= flags_q.power_on_flag && !(wr_rs && !pwdata[`WDTL_RS_POR]);
      flags_q.pin_reset_flag <= pin_reset_evt
                                || (flags_q.pin_reset_flag && !(wr_rs && !pwdata[`WDTL_RS_PIN]));
      flags_q.brownout_reset_flag <= brownout_reset_evt
                                     || (flags_q.brownout_reset_flag && !(wr_rs && !pwdata[`WDTL_RS_BOD]));
      flags_q.timeout_reset_flag <= wdt_reset_q
                                    || (flags_q.timeout_reset_flag && !(wr_rs && !pwdata[`WDTL_RS_WDT]));
      flags_q.debug_reset_flag <= debug_reset_evt
                                  || (flags_q.debug_reset_flag && !(wr_rs && !pwdata[`WDTL_RS_DBG]));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration lock: arm, then pick a level within the window.

  always_comb
  begin
    unique case (lk_q)
      wdtl_pkg::lk_armed: lock_rd = `WDTL_LOCK_ARM;
      wdtl_pkg::lk_hi: lock_rd = `WDTL_LOCK_HI;
      wdtl_pkg::lk_lo: lock_rd = `WDTL_LOCK_LO;
      default: lock_rd = 3'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lk_q <= wdtl_pkg::lk_open;
      lk_win_q <= '0;
    end
    else if (sys_rst)
    begin
      lk_q <= wdtl_pkg::lk_open;
      lk_win_q <= '0;
    end
    else
    begin
      unique case (lk_q)
        wdtl_pkg::lk_open:
        begin
          if (wr_lock && (pwdata[2:0] == `WDTL_LOCK_ARM))
          begin
            lk_q <= wdtl_pkg::lk_armed;
            lk_win_q <= `WDTL_WINDOW;
          end
        end
        wdtl_pkg::lk_armed:
        begin
          lk_win_q <= lk_win_q - 3'h1;
          if (wr_lock && (pwdata[2:0] == `WDTL_LOCK_HI))
          begin
            lk_q <= wdtl_pkg::lk_hi;
          end
          else if (wr_lock && (pwdata[2:0] == `WDTL_LOCK_LO))
          begin
            lk_q <= wdtl_pkg::lk_lo;
          end
          else if (wr_lock || (lk_win_q == 3'h1))
          begin
            lk_q <= wdtl_pkg::lk_open;
          end
        end
        wdtl_pkg::lk_hi, wdtl_pkg::lk_lo:
        begin
          lk_q <= lk_q;
        end
        default:
        begin
          lk_q <= wdtl_pkg::lk_open;
        end
      endcase
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign wdt_irq = wdt_irq_q;
  assign wdt_reset = wdt_reset_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_lock_arm;
    wr_lock && (pwdata[2:0] == `WDTL_LOCK_ARM) && (lk_q == wdtl_pkg::lk_open) && !sys_rst;
  endsequence

  sequence s_lock_hi;
    wr_lock && (pwdata[2:0] == `WDTL_LOCK_HI) && !sys_rst;
  endsequence

  a_restart_clears: assert property (restart_instr |=> count == '0) else $error("restart kept count");
  a_window_close: assert property (disable iff (!presetn || sys_rst) $rose(ctrl_q.chg_en)
    |-> ctrl_q.chg_en[*4] ##1 !ctrl_q.chg_en) else $error("change window length wrong");
  a_presc_guard: assert property (!ctrl_q.chg_en && !sys_rst |=> $stable(presc))
    else $error("prescale changed outside window");
  a_rst_en_held: assert property (flags_q.timeout_reset_flag && !sys_rst |=> ctrl_q.rst_en)
    else $error("reset enable dropped with flag set");
  a_fuse_reset: assert property (always_on_fuse && expire |=> wdt_reset_q ##1 flags_q.timeout_reset_flag)
    else $error("fuse time-out gave no reset");
  a_irq_gate: assert property (wdt_irq_q |-> $past(ctrl_q.irq_flag && irq_en_eff && gie_q))
    else $error("interrupt without enables");
  a_irq_periodic: assert property (expire && irq_en_eff && !rst_en_eff |=> ctrl_q.irq_flag && !wdt_reset_q
    && count == '0) else $error("interrupt time-out wrong");
  a_combined_rst: assert property (expire && rst_en_eff && irq_en_eff && ctrl_q.irq_flag |=> wdt_reset_q)
    else $error("unserviced time-out gave no reset");
  a_vector_clear: assert property (irq_vector_ack && rst_en_eff && irq_en_eff && !expire && !sys_rst
    |=> !ctrl_q.irq_en && !ctrl_q.irq_flag) else $error("vector did not leave reset mode");
  a_lock_ignore: assert property (lock_hi && wr_ctrl && !irq_vector_ack && !sys_rst |=> $stable(ctrl_q.irq_en))
    else $error("locked bit was written");
  a_lock_seq: assert property (s_lock_arm ##1 (!wr_lock && !sys_rst)[*2] ##1 s_lock_hi |=> lock_hi)
    else $error("lock sequence did not lock");
  a_por_sticky: assert property (flags_q.power_on_flag && !(wr_rs && !pwdata[`WDTL_RS_POR]) |=> flags_q.power_on_flag)
    else $error("power-on flag lost");

endmodule

`default_nettype wire

/* verification/wdtl_top_tb.sv */
/*
  Self-checking bench of the watchdog block: APB tasks and directed register sequences.
  Assumes osc_tick is high on every pclk cycle but in one frozen span, so periods count pclk cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wdtl_regs.svh"

module wdtl_top_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic fuse = 1'b0;
  logic osc = 1'b1;
  logic [4:0] ev = 5'h00;
  logic wdt_irq;
  logic wdt_reset;
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int rst_cnt = 0;
  int t1;
  int t2;
  int r0;
  logic [31:0] rv;
  logic ev_err;

  always #50 pclk = ~pclk;

  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (wdt_reset === 1'b1)
      rst_cnt <= rst_cnt + 1;
  end

  wdtl_top wdtl_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_tick(osc), .always_on_fuse(fuse), .restart_instr(ev[0]), .irq_vector_ack(ev[1]),
    .pin_reset_evt(ev[2]), .brownout_reset_evt(ev[3]), .debug_reset_evt(ev[4]),
    .wdt_irq(wdt_irq), .wdt_reset(wdt_reset)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task wrap_up;
    if (num_errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // The wait is bounded so that a slave that never answers shows up as a mismatch, not a hang.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    check("pready", pready, 1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] x, input string nm);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 8'h00, r, e);
    check(nm, r, {24'h00_0000, x});
  endtask

  task pulse(input int k);
    @(posedge pclk);
    ev[k] <= 1'b1;
    @(posedge pclk);
    ev <= 5'h00;
  endtask

  task automatic wait_irq(output int t);
    int n;
    n = 0;
    while (wdt_irq !== 1'b1 && n < 9000)
    begin
      @(posedge pclk);
      n++;
    end
    check("irq wait", n < 9000, 1);
    t = cyc;
  endtask

  task automatic wait_rst(input int c0);
    int n;
    n = 0;
    while (rst_cnt == c0 && n < 5000)
    begin
      @(posedge pclk);
      n++;
    end
    check("reset wait", rst_cnt != c0, 1);
  endtask

  // Clearing the watchdog flag first is what lets reset-enable go low afterwards.
  task cleanup;
    wr(`WDTL_OFS_RSTSRC, 8'h00);
    pulse(0);
    wr(`WDTL_OFS_CTRL, 8'h18);
    wr(`WDTL_OFS_CTRL, 8'h00);
    rd(`WDTL_OFS_CTRL, 8'h00, "ctrl cleanup");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (60000) @(posedge pclk);
    num_errors++;
    wrap_up();
  end

  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(`WDTL_OFS_RSTSRC, 8'h01, "rstsrc reset");
    rd(`WDTL_OFS_CTRL, 8'h00, "ctrl reset");
    rd(`WDTL_OFS_LOCK, 8'h00, "lock reset");
    rd(`WDTL_OFS_AUX, 8'h00, "aux reset");
    apb(1'b0, 12'h070, 8'h00, rv, ev_err);
    check("unmapped err", ev_err, 1);
    check("unmapped data", rv, 32'h0000_0000);
    apb(1'b1, 12'h070, 8'hFF, rv, ev_err);
    check("unmapped wr err", ev_err, 1);
    wr(`WDTL_OFS_RSTSRC, 8'h00);
    rd(`WDTL_OFS_RSTSRC, 8'h00, "por clear");
    pulse(2);
    rd(`WDTL_OFS_RSTSRC, 8'h02, "pin flag");
    pulse(3);
    rd(`WDTL_OFS_RSTSRC, 8'h06, "bod flag");
    pulse(4);
    rd(`WDTL_OFS_RSTSRC, 8'h16, "dbg flag");
    wr(`WDTL_OFS_RSTSRC, 8'h1F);
    rd(`WDTL_OFS_RSTSRC, 8'h16, "flags kept");
    wr(`WDTL_OFS_RSTSRC, 8'h00);
    rd(`WDTL_OFS_RSTSRC, 8'h00, "flags clear");
    // Timed change window.
    wr(`WDTL_OFS_CTRL, 8'h01);
    rd(`WDTL_OFS_CTRL, 8'h00, "presc no window");
    pulse(0);
    wr(`WDTL_OFS_CTRL, 8'h18);
    rd(`WDTL_OFS_CTRL, 8'h18, "chg_en set");
    rd(`WDTL_OFS_CTRL, 8'h08, "chg_en expired");
    wr(`WDTL_OFS_CTRL, 8'h00);
    rd(`WDTL_OFS_CTRL, 8'h08, "rst_en kept");
    wr(`WDTL_OFS_CTRL, 8'h18);
    wr(`WDTL_OFS_CTRL, 8'h21);
    rd(`WDTL_OFS_CTRL, 8'h21, "code 9");
    wr(`WDTL_OFS_CTRL, 8'h18);
    wr(`WDTL_OFS_CTRL, 8'h2A);
    rd(`WDTL_OFS_CTRL, 8'h29, "reserved code");
    wr(`WDTL_OFS_CTRL, 8'h18);
    wr(`WDTL_OFS_CTRL, 8'h01);
    rd(`WDTL_OFS_CTRL, 8'h01, "stopped");
    r0 = rst_cnt;
    repeat (5000) @(posedge pclk);
    check("irq stopped", wdt_irq, 0);
    check("reset stopped", rst_cnt, r0);
    rd(`WDTL_OFS_CTRL, 8'h01, "no flag stopped");
    // Interrupt mode periods for two codes.
    wr(`WDTL_OFS_AUX, 8'h01);
    for (int c = 1; c >= 0; c--)
    begin
      wr(`WDTL_OFS_CTRL, 8'h18);
      wr(`WDTL_OFS_CTRL, 8'(c));
      wr(`WDTL_OFS_CTRL, 8'(8'h40 | c));
      wait_irq(t1);
      wr(`WDTL_OFS_CTRL, 8'(8'hC0 | c));
      rd(`WDTL_OFS_CTRL, 8'(8'h40 | c), "flag w1c");
      wait_irq(t2);
      check("period", t2 - t1, 2048 << c);
      wr(`WDTL_OFS_CTRL, 8'(8'hC0 | c));
    end
    wr(`WDTL_OFS_AUX, 8'h00);
    repeat (2100) @(posedge pclk);
    rd(`WDTL_OFS_CTRL, 8'hC0, "flag no gie");
    check("irq masked", wdt_irq, 0);
    wr(`WDTL_OFS_AUX, 8'h01);
    repeat (3) @(posedge pclk);
    check("irq gie", wdt_irq, 1);
    pulse(1);
    rd(`WDTL_OFS_CTRL, 8'h40, "vector clears");
    for (int i = 0; i < 6; i++)
    begin
      repeat (1000) @(posedge pclk);
      pulse(0);
    end
    check("restart holds off", wdt_irq, 0);
    rd(`WDTL_OFS_CTRL, 8'h40, "no flag restart");
    // Without oscillator ticks the count must freeze, longer than one period.
    @(posedge pclk);
    osc <= 1'b0;
    repeat (3000) @(posedge pclk);
    check("irq no tick", wdt_irq, 0);
    rd(`WDTL_OFS_CTRL, 8'h40, "no flag no tick");
    @(posedge pclk);
    osc <= 1'b1;
    // Combined mode, serviced and then not serviced.
    wr(`WDTL_OFS_CTRL, 8'h48);
    wait_irq(t1);
    pulse(1);
    rd(`WDTL_OFS_CTRL, 8'h08, "combined vector");
    wait_rst(rst_cnt);
    rd(`WDTL_OFS_RSTSRC, 8'h08, "wdt flag");
    rd(`WDTL_OFS_CTRL, 8'h08, "rst_en forced");
    wr(`WDTL_OFS_CTRL, 8'h18);
    wr(`WDTL_OFS_CTRL, 8'h00);
    rd(`WDTL_OFS_CTRL, 8'h08, "rst_en held");
    cleanup();
    // The earlier watchdog reset cleared the global enable, so set it again.
    wr(`WDTL_OFS_AUX, 8'h01);
    wr(`WDTL_OFS_CTRL, 8'h48);
    wait_irq(t1);
    wait_rst(rst_cnt);
    cleanup();
    // Always-on fuse.
    pulse(0);
    @(posedge pclk);
    fuse <= 1'b1;
    rd(`WDTL_OFS_CTRL, 8'h08, "fuse forces");
    wr(`WDTL_OFS_CTRL, 8'h40);
    rd(`WDTL_OFS_CTRL, 8'h08, "fuse no irq");
    wait_rst(rst_cnt);
    rd(`WDTL_OFS_RSTSRC, 8'h08, "fuse wdt flag");
    @(posedge pclk);
    fuse <= 1'b0;
    cleanup();
    // Lock levels.
    wr(`WDTL_OFS_LOCK, 8'hFF);
    rd(`WDTL_OFS_LOCK, 8'h07, "lock reserved");
    wr(`WDTL_OFS_LOCK, 8'h07);
    wr(`WDTL_OFS_LOCK, 8'h04);
    rd(`WDTL_OFS_LOCK, 8'h04, "lock hi");
    wr(`WDTL_OFS_CTRL, 8'h40);
    rd(`WDTL_OFS_CTRL, 8'h00, "hi locked");
    pulse(2);
    rd(`WDTL_OFS_LOCK, 8'h00, "lock released");
    wr(`WDTL_OFS_RSTSRC, 8'h00);
    wr(`WDTL_OFS_LOCK, 8'h07);
    wr(`WDTL_OFS_LOCK, 8'h02);
    rd(`WDTL_OFS_LOCK, 8'h02, "lock lo");
    wr(`WDTL_OFS_CTRL, 8'h40);
    rd(`WDTL_OFS_CTRL, 8'h40, "lo irq_en free");
    wr(`WDTL_OFS_CTRL, 8'h58);
    rd(`WDTL_OFS_CTRL, 8'h40, "lo locked");
    wr(`WDTL_OFS_CTRL, 8'h00);
    wrap_up();
  end
endmodule
`default_nettype wire
